// >>> rtl/rlsc_regs.sv
// Purpose: APB register bank for receiver amplitude, digital LOS, slicer
// Assumes: Recovered bit stream arrives synchronous to CORE_CLK_I
// Notes:   Byte-wide registers sit in the low bits of aligned words
//
// Behaviour
// - High register: top two amplitude bits, rest zero; full scale 1022 mV
// - LOS asserts after (assert*5+2)*1024 identical bits.
// - LOS clears after clear*16+1 good 1024-bit blocks.
// - Slicer mode: off, auto, duty, proportional, absolute.
// - Slice level is 16-bit two's complement, low then high register.
// - Absolute mode maps level linearly to -240..+240 mV.
// - Proportional threshold is 50% plus level/65536.
// - Duty mode is 50% plus level/1310; codes 8586H to 7A7AH.
// - High byte waits in shadow; both apply on low-byte write.
// - High byte read before low write may show old value.
// - LOS mode: off, zeros, ones, either.
// - Read-only LOS flag plus value of the stuck bit.
// - Amplitude low eight bits in separate read-only register.
`timescale 1ns/1ps
`default_nettype none
module rlsc_regs (
    input  wire logic        CORE_CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic [9:0]  AMP_READING_I,
    input  wire logic        RX_BIT_VLD_I,
    input  wire logic        RX_BIT_I,
    output logic      [2:0]  SLICER_MODE_O,
    output logic      [15:0] SLICER_LEVEL_O,
    output logic             LOS_FLAG_O,
    output logic             IRQ_O
);
    typedef struct packed {
        logic [7:0]  assert_set;
        logic [7:0]  release_set;
        logic [3:0]  slc_upper;   // Fixed-value nibble, stored as written
        logic [2:0]  slc_mode;
        logic [7:0]  lvl_lo;
        logic [7:0]  lvl_hi;      // Active high byte
        logic [7:0]  lvl_shadow;  // Pending high byte
        logic [1:0]  los_mode;
        logic [1:0]  irq_st;
        logic [1:0]  irq_en;
        logic        flag_prev;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic        los_out;
    } rlsc_reg_type;
    rlsc_reg_type r_q, r_d;
    rlsc_los_if   los_bus ();
    // Byte address to register index
    function automatic logic [7:0] reg_idx(input logic [11:0] a);
        reg_idx = a[9:2];
    endfunction : reg_idx
    // ****************************************************************
    // LOS detector
    // ****************************************************************
    assign los_bus.assert_set  = r_q.assert_set;
    assign los_bus.release_set = r_q.release_set;
    assign los_bus.mode        = rlsc_pkg::rlsc_los_mode_type'(r_q.los_mode);
    rlsc_los_det u_det (
        .clk_i     (CORE_CLK_I),
        .rst_n_i   (RST_N_I),
        .bit_vld_i (RX_BIT_VLD_I),
        .bit_i     (RX_BIT_I),
        .los       (los_bus.det)
    );
    // ****************************************************************
    // Register next state
    // ****************************************************************
    always_comb begin
        logic       acc;
        logic       wr;
        logic [7:0] idx;
        logic [7:0] wb;
        logic [1:0] ev;
        logic [1:0] clr;
        r_d   = r_q;
        acc   = PSEL_I && PENABLE_I && !r_q.pready;
        wr    = acc && PWRITE_I;
        idx   = reg_idx(PADDR_I);
        wb    = PWDATA_I[7:0];
        clr   = 2'b00;
        // Single-wait-state answer: pready pulses one cycle
        r_d.pready  = acc;
        r_d.pslverr = 1'b0;
        r_d.prdata  = 32'h0000_0000;
        if (wr) begin
            case (idx)
                rlsc_pkg::IDX_ASSERT:   r_d.assert_set = wb;
                rlsc_pkg::IDX_RELEASE:  r_d.release_set = wb;
                rlsc_pkg::IDX_SLC_MODE: begin
                    r_d.slc_upper = wb[7:4];
                    r_d.slc_mode  = wb[2:0];
                end
                rlsc_pkg::IDX_SLC_LO: begin
                    r_d.lvl_lo = wb;
                    r_d.lvl_hi = r_q.lvl_shadow;
                end
                rlsc_pkg::IDX_SLC_HI:   r_d.lvl_shadow = wb;
                rlsc_pkg::IDX_LOS_CTRL: r_d.los_mode = wb[1:0];
                rlsc_pkg::IDX_IRQ_EN:   r_d.irq_en = wb[1:0];
                rlsc_pkg::IDX_IRQ_CLR:  clr = wb[1:0];
                rlsc_pkg::IDX_AMP_LO, rlsc_pkg::IDX_AMP_HI,
                rlsc_pkg::IDX_LOS_STAT, rlsc_pkg::IDX_IRQ_STAT: ;
                default:                r_d.pslverr = 1'b1;
            endcase
        end else if (acc) begin
            case (idx)
                rlsc_pkg::IDX_AMP_LO:   r_d.prdata[7:0] = AMP_READING_I[7:0];
                rlsc_pkg::IDX_AMP_HI:   r_d.prdata[1:0] = AMP_READING_I[9:8];
                rlsc_pkg::IDX_ASSERT:   r_d.prdata[7:0] = r_q.assert_set;
                rlsc_pkg::IDX_RELEASE:  r_d.prdata[7:0] = r_q.release_set;
                rlsc_pkg::IDX_SLC_MODE: r_d.prdata[7:0] =
                                            {r_q.slc_upper, 1'b0, r_q.slc_mode};
                rlsc_pkg::IDX_SLC_LO:   r_d.prdata[7:0] = r_q.lvl_lo;
                rlsc_pkg::IDX_SLC_HI:   r_d.prdata[7:0] = r_q.lvl_hi;
                rlsc_pkg::IDX_LOS_CTRL: r_d.prdata[1:0] = r_q.los_mode;
                rlsc_pkg::IDX_LOS_STAT: r_d.prdata[1:0] =
                                            {los_bus.stuck_val, los_bus.flag};
                rlsc_pkg::IDX_IRQ_STAT: r_d.prdata[1:0] = r_q.irq_st;
                rlsc_pkg::IDX_IRQ_EN:   r_d.prdata[1:0] = r_q.irq_en;
                rlsc_pkg::IDX_IRQ_CLR:  ;
                default:                r_d.pslverr = 1'b1;
            endcase
        end
        // Events: LOS raised, LOS released; set beats clear
        ev = {r_q.flag_prev && !los_bus.flag, !r_q.flag_prev && los_bus.flag};
        r_d.flag_prev = los_bus.flag;
        r_d.irq_st    = (r_q.irq_st & ~clr) | ev;
        r_d.irq       = |(r_d.irq_st & r_d.irq_en);
        r_d.los_out   = los_bus.flag;
    end
    // State register
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            r_q             <= '0;
            r_q.assert_set  <= rlsc_pkg::RST_ASSERT;
            r_q.release_set <= rlsc_pkg::RST_RELEASE;
            r_q.slc_upper   <= rlsc_pkg::RST_SLC_MODE[7:4];
            r_q.slc_mode    <= rlsc_pkg::RST_SLC_MODE[2:0];
        end else begin
            r_q <= r_d;
        end
    end
    // Slicer analog side turns the raw signed code into offset, threshold
    // or duty cycle; only mode and code leave here
    // and
    assign SLICER_MODE_O  = r_q.slc_mode;
    assign SLICER_LEVEL_O = {r_q.lvl_hi, r_q.lvl_lo};
    assign PRDATA_O       = r_q.prdata;
    assign PREADY_O       = r_q.pready;
    assign PSLVERR_O      = r_q.pslverr;
    assign LOS_FLAG_O     = r_q.los_out;
    assign IRQ_O          = r_q.irq;
    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_lvl_pair;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        PSEL_I && PENABLE_I && !r_q.pready && PWRITE_I
            && reg_idx(PADDR_I) == rlsc_pkg::IDX_SLC_HI
            |=> SLICER_LEVEL_O == $past(SLICER_LEVEL_O);
    endproperty
    a_lvl_pair: assert property (p_lvl_pair)
        else $error("Slice level changed on high byte write");
    property p_lvl_commit;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        PSEL_I && PENABLE_I && !r_q.pready && PWRITE_I
            && reg_idx(PADDR_I) == rlsc_pkg::IDX_SLC_LO
            |=> SLICER_LEVEL_O == {$past(r_q.lvl_shadow), $past(PWDATA_I[7:0])};
    endproperty
    a_lvl_commit: assert property (p_lvl_commit)
        else $error("Slice level not committed as one word");
    property p_amp_hi;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        PSEL_I && PENABLE_I && !r_q.pready && !PWRITE_I
            && reg_idx(PADDR_I) == rlsc_pkg::IDX_AMP_HI
            |=> PREADY_O && PRDATA_O == {30'h0, $past(AMP_READING_I[9:8])};
    endproperty
    a_amp_hi: assert property (p_amp_hi)
        else $error("Amplitude high read wrong");
    property p_amp_lo;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        PSEL_I && PENABLE_I && !r_q.pready && !PWRITE_I
            && reg_idx(PADDR_I) == rlsc_pkg::IDX_AMP_LO
            |=> PRDATA_O == {24'h0, $past(AMP_READING_I[7:0])};
    endproperty
    a_amp_lo: assert property (p_amp_lo)
        else $error("Amplitude low read wrong");
    property p_mode_wr;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        PSEL_I && PENABLE_I && !r_q.pready && PWRITE_I
            && reg_idx(PADDR_I) == rlsc_pkg::IDX_SLC_MODE
            |=> SLICER_MODE_O == $past(PWDATA_I[2:0]);
    endproperty
    a_mode_wr: assert property (p_mode_wr)
        else $error("Slicer mode not updated");
    property p_irq_level;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        ##1 IRQ_O == |($past(r_d.irq_st) & $past(r_d.irq_en));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("Interrupt output mismatch");
    property p_irq_sticky;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        !r_q.flag_prev && los_bus.flag
            |=> r_q.irq_st[rlsc_pkg::IRQ_BIT_SET];
    endproperty
    a_irq_sticky: assert property (p_irq_sticky)
        else $error("LOS raise event not latched in status");
endmodule : rlsc_regs
`default_nettype wire

// >>> rtl/rlsc_pkg.sv
// Purpose: Shared constants and types for the receiver LOS/slicer registers
// Assumes: APB byte addresses are four times the printed register index
// Notes:   One package, referenced by scope only
package rlsc_pkg;
    // ****************************************************************
    // Register indices (byte address = index * 4)
    // ****************************************************************
    localparam logic [7:0] IDX_AMP_LO     = 8'h0F;
    localparam logic [7:0] IDX_AMP_HI     = 8'h10;
    localparam logic [7:0] IDX_ASSERT     = 8'h11;
    localparam logic [7:0] IDX_RELEASE    = 8'h12;
    localparam logic [7:0] IDX_SLC_MODE   = 8'h14;
    localparam logic [7:0] IDX_SLC_LO     = 8'h15;
    localparam logic [7:0] IDX_SLC_HI     = 8'h16;
    localparam logic [7:0] IDX_LOS_CTRL   = 8'h20;
    localparam logic [7:0] IDX_LOS_STAT   = 8'h21;
    localparam logic [7:0] IDX_IRQ_STAT   = 8'h22;
    localparam logic [7:0] IDX_IRQ_EN     = 8'h23;
    localparam logic [7:0] IDX_IRQ_CLR    = 8'h24;
    // ****************************************************************
    // Reset values and field layout
    // ****************************************************************
    localparam logic [7:0] RST_ASSERT     = 8'h05;
    localparam logic [7:0] RST_RELEASE    = 8'h60;
    localparam logic [7:0] RST_SLC_MODE   = 8'h11;
    localparam logic [3:0] SLC_UPPER_FIX  = 4'h1;
    localparam int         BLOCK_BITS     = 1024;
    localparam int         ASSERT_MUL     = 5;
    localparam int         ASSERT_ADD     = 2;
    localparam int         RELEASE_MUL    = 16;
    localparam int         RELEASE_ADD    = 1;
    localparam int         AMP_FULL_MV    = 1022;
    localparam int         IRQ_BIT_SET    = 0;
    localparam int         IRQ_BIT_CLR    = 1;
    // ****************************************************************
    // Modes
    // ****************************************************************
    typedef enum logic [2:0] {
        SLC_OFF   = 3'h0,
        SLC_AUTO  = 3'h1,
        SLC_DUTY  = 3'h2,
        SLC_PROP  = 3'h3,
        SLC_ABS   = 3'h4
    } rlsc_slc_mode_type;
    typedef enum logic [1:0] {
        LOS_OFF   = 2'h0,
        LOS_ZEROS = 2'h1,
        LOS_ONES  = 2'h2,
        LOS_ANY   = 2'h3
    } rlsc_los_mode_type;
endpackage : rlsc_pkg

// >>> rtl/rlsc_los_if.sv
// Purpose: Carrier between register bank and LOS detector
// Assumes: Single clock domain
// Notes:   Settings flow in, status flows out
`timescale 1ns/1ps
`default_nettype none
interface rlsc_los_if;
    logic [7:0]                  assert_set;
    logic [7:0]                  release_set;
    rlsc_pkg::rlsc_los_mode_type mode;
    logic                        flag;
    logic                        stuck_val;
    modport regs (output assert_set, release_set, mode,
                  input flag, stuck_val);
    modport det  (input assert_set, release_set, mode,
                  output flag, stuck_val);
endinterface : rlsc_los_if
`default_nettype wire

// >>> rtl/rlsc_los_det.sv
// Purpose: Digital loss-of-signal detector on the recovered bit stream
// Assumes: One recovered bit per cycle while the bit valid input is high
// Notes:   Counts in 1024-bit blocks to keep counters narrow
`timescale 1ns/1ps
`default_nettype none
module rlsc_los_det (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       bit_vld_i,
    input  wire logic       bit_i,
    rlsc_los_if.det         los
);
    typedef struct packed {
        logic [9:0]  pos;     // Bit position in block
        logic [10:0] run_blk; // Identical blocks seen
        logic [12:0] clr_blk; // Good blocks seen
        logic        seen0;
        logic        seen1;
        logic        prev;
        logic        run_ok;  // Run still unbroken
        logic        flag;
        logic        stuck;
    } rlsc_det_type;
    rlsc_det_type s_q, s_d;
    logic [10:0] need_run;
    logic [12:0] need_clr;
    logic        blk_end;
    logic        trans;
    // Thresholds in blocks
    assign need_run = 11'(int'(los.assert_set) * rlsc_pkg::ASSERT_MUL
                          + rlsc_pkg::ASSERT_ADD);
    assign need_clr = 13'(int'(los.release_set) * rlsc_pkg::RELEASE_MUL
                          + rlsc_pkg::RELEASE_ADD);
    assign blk_end  = bit_vld_i &&
                      (s_q.pos == 10'(rlsc_pkg::BLOCK_BITS - 1));
    // A flip against the last bit of the previous block counts as well, so
    // a run never survives a value change that lands on a block edge
    assign trans    = bit_vld_i && (bit_i != s_q.prev);
    // ****************************************************************
    // Detector next state
    // ****************************************************************
    always_comb begin
        logic ones;
        logic zeros;
        logic counts;
        s_d    = s_q;
        ones   = s_q.seen1 || (bit_vld_i && bit_i);
        zeros  = s_q.seen0 || (bit_vld_i && !bit_i);
        counts = 1'b0;
        if (bit_vld_i) begin
            s_d.pos   = s_q.pos + 10'h001;
            s_d.prev  = bit_i;
            s_d.seen0 = zeros;
            s_d.seen1 = ones;
            if (trans) begin
                s_d.run_ok = 1'b0;
            end
        end
        if (blk_end) begin
            // Block counts as identical only with no transition inside
            case (los.mode)
                rlsc_pkg::LOS_ZEROS: counts = !ones;
                rlsc_pkg::LOS_ONES:  counts = !zeros;
                rlsc_pkg::LOS_ANY:   counts = !(ones && zeros);
                default:             counts = 1'b0;
            endcase
            // Run must also continue across the block edge
            if (counts && s_q.run_ok && !trans) begin
                s_d.run_blk = (s_q.run_blk == 11'h7FF) ? s_q.run_blk
                              : s_q.run_blk + 11'h001;
            end else if (counts) begin
                s_d.run_blk = 11'h001;
            end else begin
                s_d.run_blk = 11'h000;
            end
            if (!s_q.flag && counts &&
                s_d.run_blk >= need_run) begin
                s_d.flag  = 1'b1;
                s_d.stuck = ones;
                s_d.clr_blk = 13'h0000;
            end else if (s_q.flag) begin
                if (ones && zeros) begin
                    s_d.clr_blk = s_q.clr_blk + 13'h0001;
                    if (s_d.clr_blk >= need_clr) begin
                        s_d.flag = 1'b0;
                        s_d.clr_blk = 13'h0000;
                    end
                end else begin
                    s_d.clr_blk = 13'h0000;
                end
            end
            s_d.seen0  = 1'b0;
            s_d.seen1  = 1'b0;
            s_d.run_ok = 1'b1;
        end
        if (los.mode == rlsc_pkg::LOS_OFF) begin
            s_d.flag    = 1'b0;
            s_d.run_blk = 11'h000;
            s_d.clr_blk = 13'h0000;
        end
    end
    // State register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign los.flag      = s_q.flag;
    assign los.stuck_val = s_q.stuck;
    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_flag_only_at_block;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(s_q.flag) |-> $past(blk_end) && $past(s_q.run_blk) + 11'h001
            >= $past(need_run);
    endproperty
    a_flag_only_at_block: assert property (p_flag_only_at_block)
        else $error("LOS raised without enough identical blocks");
    property p_release_count;
        @(posedge clk_i) disable iff (!rst_n_i)
        $fell(s_q.flag) && $past(los.mode) != rlsc_pkg::LOS_OFF
            |-> $past(s_q.clr_blk) + 13'h0001 >= $past(need_clr);
    endproperty
    a_release_count: assert property (p_release_count)
        else $error("LOS released before enough good blocks");
    property p_clr_zero;
        @(posedge clk_i) disable iff (!rst_n_i)
        blk_end && s_q.flag && !(s_q.seen0 && s_q.seen1) && !trans
            |=> s_q.clr_blk == 13'h0000 || !s_q.flag;
    endproperty
    a_clr_zero: assert property (p_clr_zero)
        else $error("Release count not restarted on a dead block");
    property p_off_mode;
        @(posedge clk_i) disable iff (!rst_n_i)
        los.mode == rlsc_pkg::LOS_OFF |=> !s_q.flag;
    endproperty
    a_off_mode: assert property (p_off_mode)
        else $error("LOS flag set while detector disabled");
    property p_stuck_set;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(s_q.flag) |-> s_q.stuck == $past(s_q.seen1 || bit_i);
    endproperty
    a_stuck_set: assert property (p_stuck_set)
        else $error("Stuck value does not match the run");
endmodule : rlsc_los_det
`default_nettype wire

// >>> dv/rlsc_bit_src.sv
// Purpose: Recovered bit stream source standing in for the receive path
// Assumes: One bit per clock while valid is high
// Notes:   Data keeps changing while idle so a stale level never looks stuck
`timescale 1ns/1ps
`default_nettype none
module rlsc_bit_src (
    input  wire logic clk_i,
    output logic      vld_o,
    output logic      bit_o
);
    // ****************************************************************
    // Stream driver
    // ****************************************************************
    logic active;
    initial begin
        vld_o  = 1'b0;
        bit_o  = 1'b0;
        active = 1'b0;
    end
    // Idle pattern: no valid bits, line toggles every cycle
    always @(posedge clk_i) begin
        if (!active) begin
            bit_o <= ~bit_o;
        end
    end
    // Send n bits, either one level or alternating values
    task automatic run(input logic tgl, input logic v, input int n);
        logic b;
        b = v;
        active = 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            vld_o <= 1'b1;
            bit_o <= b;
            if (tgl) begin
                b = ~b;
            end
        end
        @(posedge clk_i);
        vld_o  <= 1'b0;
        active = 1'b0;
    endtask : run
endmodule : rlsc_bit_src
`default_nettype wire

// >>> dv/rx_los_slice_control_regs_tb.sv
// Purpose: Self-checking bench for the receiver LOS and slicer registers
// Assumes: APB slave answers with one wait cycle; bits one per clock
// Notes:   Assert and release settings of zero keep LOS runs short
`timescale 1ns/1ps
`default_nettype none
module rx_los_slice_control_regs_tb;
    // ****************************************************************
    // Signals, clock, design and stream source
    // ****************************************************************
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  amp;
    logic        rx_vld, rx_bit, los_flag, irq, er;
    logic [2:0]  slc_mode;
    logic [15:0] slc_lvl;
    int          failures, samples_checked, cycles;
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    rlsc_regs dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .AMP_READING_I(amp), .RX_BIT_VLD_I(rx_vld),
        .RX_BIT_I(rx_bit), .SLICER_MODE_O(slc_mode),
        .SLICER_LEVEL_O(slc_lvl), .LOS_FLAG_O(los_flag), .IRQ_O(irq));
    rlsc_bit_src src (.clk_i(clk), .vld_o(rx_vld), .bit_o(rx_bit));
    // Hang guard: far above the ~12k cycles the scenarios need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            stop_test();
        end
    end
    // ****************************************************************
    // Bus and compare helpers
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask : chk
    // Request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [7:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [7:0] idx, input logic [7:0] e,
                       input string nm);
        apb(1'b0, idx, 8'h00);
        chk(nm, {24'h0, e}, rd);
        chk("pslverr", 32'h0, {31'h0, er});
    endtask : rdc
    task automatic settle(input logic e, input string nm);
        repeat (8) @(posedge clk);
        chk(nm, {31'h0, e}, {31'h0, los_flag});
    endtask : settle
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        rdc(rlsc_pkg::IDX_ASSERT, 8'h05, "assert rst");
        rdc(rlsc_pkg::IDX_RELEASE, 8'h60, "release rst");
        rdc(rlsc_pkg::IDX_SLC_MODE, 8'h11, "mode rst");
        rdc(rlsc_pkg::IDX_SLC_LO, 8'h00, "lvl lo rst");
        rdc(rlsc_pkg::IDX_SLC_HI, 8'h00, "lvl hi rst");
        rdc(rlsc_pkg::IDX_LOS_STAT, 8'h00, "los stat rst");
    endtask : t_reset
    // Low byte read first, then the two top bits; RO write has no effect
    task automatic t_amp;
        amp <= 10'h2A5;
        rdc(rlsc_pkg::IDX_AMP_LO, 8'hA5, "amp lo");
        rdc(rlsc_pkg::IDX_AMP_HI, 8'h02, "amp hi");
        amp <= 10'h3FF;
        apb(1'b1, rlsc_pkg::IDX_AMP_HI, 8'hFF);
        chk("ro write err", 32'h0, {31'h0, er});
        rdc(rlsc_pkg::IDX_AMP_LO, 8'hFF, "amp lo fs");
        rdc(rlsc_pkg::IDX_AMP_HI, 8'h03, "amp hi fs");
        apb(1'b0, 8'h13, 8'h00);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
    endtask : t_amp
    task automatic t_mode;
        for (int m = 0; m < 5; m++) begin
            apb(1'b1, rlsc_pkg::IDX_SLC_MODE,
                {rlsc_pkg::SLC_UPPER_FIX, 1'b0, m[2:0]});
            repeat (2) @(posedge clk);
            chk("slicer mode", m, {29'h0, slc_mode});
            rdc(rlsc_pkg::IDX_SLC_MODE, {rlsc_pkg::SLC_UPPER_FIX, 1'b0,
                m[2:0]}, "mode rd");
        end
    endtask : t_mode
    // Upper byte waits in the shadow until the lower byte lands
    task automatic t_level;
        apb(1'b1, rlsc_pkg::IDX_SLC_HI, 8'h80);
        repeat (2) @(posedge clk);
        chk("lvl pending", 32'h0, {16'h0, slc_lvl});
        rdc(rlsc_pkg::IDX_SLC_HI, 8'h00, "lvl hi pend");
        apb(1'b1, rlsc_pkg::IDX_SLC_LO, 8'h00);
        repeat (2) @(posedge clk);
        chk("lvl min", 32'h8000, {16'h0, slc_lvl});
        apb(1'b1, rlsc_pkg::IDX_SLC_HI, 8'h7A);
        apb(1'b1, rlsc_pkg::IDX_SLC_LO, 8'h86);
        repeat (2) @(posedge clk);
        chk("lvl pair", 32'h7A86, {16'h0, slc_lvl});
        rdc(rlsc_pkg::IDX_SLC_LO, 8'h86, "lvl lo rd");
        rdc(rlsc_pkg::IDX_SLC_HI, 8'h7A, "lvl hi rd");
    endtask : t_level
    // Settings of zero: assert after 2048 equal bits, release after 1 block
    task automatic t_los;
        apb(1'b1, rlsc_pkg::IDX_ASSERT, 8'h00);
        apb(1'b1, rlsc_pkg::IDX_RELEASE, 8'h00);
        apb(1'b1, rlsc_pkg::IDX_IRQ_EN, 8'h01);
        apb(1'b1, rlsc_pkg::IDX_LOS_CTRL, 8'h01);
        src.run(1'b0, 1'b1, 2048);
        settle(1'b0, "ones in zero mode");
        src.run(1'b0, 1'b0, 2047);
        settle(1'b0, "one bit short");
        src.run(1'b0, 1'b0, 1);
        settle(1'b1, "zeros assert");
        rdc(rlsc_pkg::IDX_LOS_STAT, 8'h01, "stuck zero");
        rdc(rlsc_pkg::IDX_IRQ_STAT, 8'h01, "irq raised");
        chk("irq on", 32'h1, {31'h0, irq});
        apb(1'b1, rlsc_pkg::IDX_IRQ_CLR, 8'h01);
        repeat (3) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        src.run(1'b0, 1'b0, 1024);
        settle(1'b1, "dead block holds");
        src.run(1'b1, 1'b0, 1023);
        settle(1'b1, "release short");
        src.run(1'b0, 1'b1, 1);
        settle(1'b0, "released");
        rdc(rlsc_pkg::IDX_IRQ_STAT, 8'h02, "irq released");
        apb(1'b1, rlsc_pkg::IDX_LOS_CTRL, 8'h02);
        src.run(1'b0, 1'b1, 2048);
        settle(1'b1, "ones assert");
        rdc(rlsc_pkg::IDX_LOS_STAT, 8'h03, "stuck one");
        apb(1'b1, rlsc_pkg::IDX_LOS_CTRL, 8'h00);
        settle(1'b0, "mode off");
        apb(1'b1, rlsc_pkg::IDX_LOS_CTRL, 8'h03);
        src.run(1'b0, 1'b1, 1024);
        src.run(1'b0, 1'b0, 1024);
        settle(1'b0, "edge breaks run");
        src.run(1'b0, 1'b0, 1024);
        settle(1'b1, "either assert");
        rdc(rlsc_pkg::IDX_LOS_STAT, 8'h01, "stuck any");
    endtask : t_los
    // ****************************************************************
    // Main sequence and verdict
    // ****************************************************************
    task automatic stop_test;
        $display("Checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    initial begin
        rst_n   = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        amp     = 10'h000;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_amp();
        t_mode();
        t_level();
        t_los();
        stop_test();
    end
endmodule : rx_los_slice_control_regs_tb
`default_nettype wire
